// ---- rtl/gcar_regs.sv ----
// gauge settings, alert and command register bank
`timescale 1ns/100ps
module gcar_regs #(
    // width of the whole-percent charge value
    parameter int CHARGE_W = 8,
    // fixed read value of the don't-care bit
    parameter bit DONTCARE_READ = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // word writes from the serial engine
    input wire gcar_pkg::gcar_wr_req_t wr_req,
    // word reads from the serial engine
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    // answer to the serial engine
    output logic no_ack,
    // charge estimate from the gauging logic
    input wire logic [CHARGE_W-1:0] charge_pct,
    input wire logic charge_valid,
    // hardware restart pin, asynchronous
    input wire logic restart_estimate_pin,
    // controls toward the gauging logic
    output logic [7:0] battery_comp_value,
    output logic gauge_run,
    output logic sleep_mode,
    output logic quick_start,
    output logic full_reset,
    // low active alert pin
    output logic alert_pin_n
);

    // the threshold must be representable on the charge scale
    if (CHARGE_W < 6) begin : g_width_check
        $error("gcar_regs: CHARGE_W must be at least 6");
    end

    gcar_pkg::gcar_state_t st_ff; // registered state
    gcar_pkg::gcar_state_t nxt_st; // next state
    gcar_pkg::gcar_state_t rst_st; // state after any reset

    logic restart_rise; // synchronised restart edge
    logic charge_below; // charge under threshold
    logic wr_ok; // whole word write accepted
    logic wr_settings; // write to the settings word
    logic wr_command; // write to the command word
    logic cmd_reset; // full reset command seen
    logic [15:0] settings_word; // settings as read back

    // restart pin crosses in through two flops first
    gcar_pin_sync u_restart_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(restart_estimate_pin),
        .level_out(),
        .rise_out(restart_rise)
    );

    // threshold decode and compare
    gcar_alert_cmp #(
        .CHARGE_W(CHARGE_W)
    ) u_alert_cmp (
        .charge_pct(charge_pct),
        .level_code(st_ff.cfg.level_code),
        .level_pct(),
        .below(charge_below)
    );

    // power-up values, shared by the pin reset and the command
    always_comb begin
        rst_st = '0;
        rst_st.cfg.comp = gcar_pkg::GCAR_COMP_RST;
        rst_st.cfg.sleep = gcar_pkg::GCAR_SLEEP_RST;
        rst_st.cfg.flag = gcar_pkg::GCAR_FLAG_RST;
        rst_st.cfg.level_code = gcar_pkg::GCAR_LEVEL_RST;
        // alerting is live from power-up on
        rst_st.armed = 1'b1;
        rst_st.alert_n = 1'b1;
        rst_st.run = 1'b1;
    end

    // write decode: a word cut short never reaches a register
    always_comb begin
        wr_ok = wr_req.valid & wr_req.complete;
        wr_settings = wr_ok & (wr_req.addr == gcar_pkg::GCAR_SETTINGS_ADDR);
        wr_command = wr_ok & (wr_req.addr == gcar_pkg::GCAR_COMMAND_ADDR);
        // reserved command codes fall through with no effect
        cmd_reset = wr_command &
            (wr_req.data == gcar_pkg::GCAR_CMD_FULL_RESET);
    end

    // settings word as the host sees it
    always_comb begin
        settings_word = '0;
        settings_word[gcar_pkg::GCAR_COMP_LSB +: 8] = st_ff.cfg.comp;
        settings_word[gcar_pkg::GCAR_SLEEP_BIT] = st_ff.cfg.sleep;
        // the don't-care bit has no storage at all
        settings_word[gcar_pkg::GCAR_DONTCARE_BIT] = DONTCARE_READ;
        settings_word[gcar_pkg::GCAR_FLAG_BIT] = st_ff.cfg.flag;
        settings_word[gcar_pkg::GCAR_LEVEL_LSB +: 5] =
            st_ff.cfg.level_code;
    end

    // next state of the whole bank
    always_comb begin
        nxt_st = st_ff;
        // pulses last one cycle
        nxt_st.quick_start = 1'b0;
        nxt_st.full_reset = 1'b0;
        nxt_st.no_ack = 1'b0;

        // host write of the settings word
        if (wr_settings) begin
            // compensation is stored verbatim, no clamping
            nxt_st.cfg.comp =
                wr_req.data[gcar_pkg::GCAR_COMP_LSB +: 8];
            // sleep follows the written bit both ways
            nxt_st.cfg.sleep =
                wr_req.data[gcar_pkg::GCAR_SLEEP_BIT];
            nxt_st.cfg.level_code =
                wr_req.data[gcar_pkg::GCAR_LEVEL_LSB +: 5];
            // writing one is no way to raise the flag
            if (!wr_req.data[gcar_pkg::GCAR_FLAG_BIT]) begin
                nxt_st.cfg.flag = 1'b0;
            end
        end

        // alert check on each fresh estimate while awake;
        // estimates that arrive in sleep are ignored and cannot alert
        if (charge_valid && !st_ff.cfg.sleep) begin
            if (charge_below) begin
                // fire once per downward crossing
                if (st_ff.armed) begin
                    nxt_st.cfg.flag = 1'b1;
                    nxt_st.armed = 1'b0;
                end
            end else begin
                // back at or above level: next fall may alert
                nxt_st.armed = 1'b1;
            end
        end

        // gauging runs only while not asleep; a hold, not a clear,
        // so the estimator picks up where it stopped
        nxt_st.run = ~nxt_st.cfg.sleep;

        // pin follows the flag; sleep leaves both untouched
        nxt_st.alert_n = ~nxt_st.cfg.flag;

        // restart pin edge asks for a fresh first estimate
        if (restart_rise) begin
            nxt_st.quick_start = 1'b1;
        end

        // read data registered, one cycle behind the address;
        // unlisted addresses read zero
        if (rd_addr == gcar_pkg::GCAR_SETTINGS_ADDR) begin
            nxt_st.rd_data = settings_word;
        end else begin
            nxt_st.rd_data = '0;
        end

        // full reset command beats everything else this cycle
        if (cmd_reset) begin
            nxt_st = rst_st;
            nxt_st.full_reset = 1'b1;
            nxt_st.no_ack = 1'b1;
        end
    end

    // single register stage for the whole bank
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= rst_st;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs taken straight from the state flops
    assign rd_data = st_ff.rd_data;
    assign no_ack = st_ff.no_ack;
    assign battery_comp_value = st_ff.cfg.comp;
    assign gauge_run = st_ff.run;
    assign sleep_mode = st_ff.cfg.sleep;
    assign quick_start = st_ff.quick_start;
    assign full_reset = st_ff.full_reset;
    assign alert_pin_n = st_ff.alert_n;

endmodule // gcar_regs

// ---- pkg/gcar_pkg.sv ----
// gauge settings/alert register bank: shared constants and carrier types
package gcar_pkg;

    // register byte addresses as seen by the serial engine
    localparam logic [7:0] GCAR_SETTINGS_ADDR = 8'h0C;
    localparam logic [7:0] GCAR_COMMAND_ADDR = 8'hFE;

    // field positions inside the settings word
    localparam int GCAR_COMP_LSB = 8;
    localparam int GCAR_SLEEP_BIT = 7;
    localparam int GCAR_DONTCARE_BIT = 6;
    localparam int GCAR_FLAG_BIT = 5;
    localparam int GCAR_LEVEL_LSB = 0;

    // reset values of the settings fields
    localparam logic [7:0] GCAR_COMP_RST = 8'h97;
    localparam logic GCAR_SLEEP_RST = 1'b0;
    localparam logic GCAR_FLAG_RST = 1'b0;
    localparam logic [4:0] GCAR_LEVEL_RST = 5'h1C;

    // the one listed command code: full reset
    localparam logic [15:0] GCAR_CMD_FULL_RESET = 16'h0054;

    // threshold arithmetic: percent = span - code
    localparam logic [5:0] GCAR_LEVEL_SPAN = 6'h20;

    // one finished word write from the serial engine
    typedef struct packed {
        logic valid;         // one-cycle strobe
        logic [7:0] addr;    // register byte address
        logic [15:0] data;   // word, msb first on the wire
        logic complete;      // all sixteen bits arrived
    } gcar_wr_req_t;

    // host-visible settings fields
    typedef struct packed {
        logic [7:0] comp;
        logic sleep;
        logic flag;
        logic [4:0] level_code;
    } gcar_settings_t;

    // whole state of the register bank
    typedef struct packed {
        gcar_settings_t cfg;
        logic armed;         // below-threshold may raise an alert
        logic alert_n;       // alert pin, low active
        logic run;           // gauging allowed
        logic [15:0] rd_data;
        logic no_ack;        // suppress ack of the command transfer
        logic full_reset;    // device-wide reset pulse
        logic quick_start;   // restart estimate pulse
    } gcar_state_t;

    // state of the pin synchroniser and edge finder
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
    } gcar_sync_t;

endpackage

// ---- rtl/gcar_pin_sync.sv ----
// two-stage pin synchroniser with rising edge pulse
`timescale 1ns/100ps
module gcar_pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous pin
    input wire logic pin_in,
    // synchronised level and edge
    output logic level_out,
    output logic rise_out
);

    gcar_pkg::gcar_sync_t st_ff; // registered state
    gcar_pkg::gcar_sync_t nxt_st; // next state

    // the edge finder looks only at the second stage, never at meta
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = pin_in;
        nxt_st.sync = st_ff.meta;
        nxt_st.prev = st_ff.sync;
        nxt_st.rise = st_ff.sync & ~st_ff.prev;
    end

    // all stages reset high: a pin already high at reset gives no
    // edge, and a low pin only falls, which the finder ignores
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, rise: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.sync;
    assign rise_out = st_ff.rise;

endmodule // gcar_pin_sync

// ---- rtl/gcar_alert_cmp.sv ----
// alert threshold decode and charge comparison
`timescale 1ns/100ps
module gcar_alert_cmp #(
    parameter int CHARGE_W = 8
) (
    // charge in whole percent
    input wire logic [CHARGE_W-1:0] charge_pct,
    // complemented threshold code
    input wire logic [4:0] level_code,
    // decoded level and comparison
    output logic [5:0] level_pct,
    output logic below
);

    logic [CHARGE_W-1:0] level_wide; // level at charge width

    // code 0 is 32 percent, code 31 is 1 percent
    always_comb begin
        level_pct = gcar_pkg::GCAR_LEVEL_SPAN - {1'b0, level_code};
        level_wide = CHARGE_W'(level_pct);
        below = charge_pct < level_wide;
    end

endmodule // gcar_alert_cmp

// ---- tb/gcar_monitor.sv ----
// assertion checker for the gauge register bank ports
`timescale 1ns/100ps
module gcar_monitor #(
    parameter int CHARGE_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched bank ports
    input wire gcar_pkg::gcar_wr_req_t wr_req,
    input wire logic [7:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic no_ack,
    input wire logic [CHARGE_W-1:0] charge_pct,
    input wire logic charge_valid,
    input wire logic restart_estimate_pin,
    input wire logic [7:0] battery_comp_value,
    input wire logic gauge_run,
    input wire logic sleep_mode,
    input wire logic quick_start,
    input wire logic full_reset,
    input wire logic alert_pin_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // decoded write kinds; partial words never count
    logic set_wr;
    logic cmd_wr;
    logic clr_wr;
    assign set_wr = wr_req.valid && wr_req.complete && wr_req.addr == 8'h0C;
    assign cmd_wr = wr_req.valid && wr_req.complete && wr_req.addr == 8'hFE
        && wr_req.data == 16'h0054;
    assign clr_wr = set_wr && !wr_req.data[5];
    property p_comp;
        set_wr |=> battery_comp_value == $past(wr_req.data[15:8]);
    endproperty
    a_comp: assert property (p_comp) else $error("comp byte lost");
    property p_sleep;
        set_wr |=> sleep_mode == $past(wr_req.data[7]) && gauge_run != sleep_mode;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep bad");
    property p_part;
        wr_req.valid && !wr_req.complete |=> $stable(battery_comp_value)
            && $stable(sleep_mode) && !full_reset;
    endproperty
    a_part: assert property (p_part) else $error("partial taken");
    property p_por;
        cmd_wr |=> full_reset && no_ack && battery_comp_value == 8'h97
            && !sleep_mode && alert_pin_n && rd_data == 16'h0000
            ##1 !full_reset;
    endproperty
    a_por: assert property (p_por) else $error("full reset bad");
    property p_bad;
        wr_req.valid && wr_req.addr == 8'hFE && wr_req.data != 16'h0054
            |=> !full_reset;
    endproperty
    a_bad: assert property (p_bad) else $error("reserved acted");
    property p_fire;
        $fell(alert_pin_n) |-> $past(charge_valid) && !$past(sleep_mode);
    endproperty
    a_fire: assert property (p_fire) else $error("alert w/o cause");
    property p_hold;
        !alert_pin_n && !clr_wr && !cmd_wr |=> !alert_pin_n;
    endproperty
    a_hold: assert property (p_hold) else $error("alert dropped");
    property p_qs;
        $rose(restart_estimate_pin) |-> ##4 quick_start;
    endproperty
    a_qs: assert property (p_qs) else $error("no quick start");
    property p_rd;
        rd_addr == 8'h0C && !cmd_wr |=> rd_data[6] == 1'b0
            && rd_data[15:8] == $past(battery_comp_value);
    endproperty
    a_rd: assert property (p_rd) else $error("read word bad");
    // main scenarios reached
    c_fire: cover property ($fell(alert_pin_n));
    c_por: cover property (full_reset);
    c_qs: cover property (quick_start);
endmodule // gcar_monitor

// ---- tb/gcar_host.sv ----
// host side model issuing whole or partial word writes and reads
`timescale 1ns/100ps
module gcar_host (
    // clock
    input wire logic clk,
    // answer from the bank
    input wire logic [15:0] rd_data,
    // requests toward the bank
    output gcar_pkg::gcar_wr_req_t wr_req,
    output logic [7:0] rd_addr
);
    initial begin
        wr_req = '0;
        rd_addr = 8'h00;
    end
    // one-cycle strobe; released fields inverted so stale data never helps
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic whole);
        @(negedge clk);
        wr_req = '{1'b1, a, d, whole};
        @(negedge clk);
        wr_req = '{1'b0, ~a, ~d, ~whole};
    endtask
    // read data lands on the same edge that samples the address
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(negedge clk);
        rd_addr = a;
        @(negedge clk);
        q = rd_data;
    endtask
endmodule // gcar_host

// ---- tb/tb.sv ----
// self-checking bench for the gauge register bank
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    err_count++; $display("BAD %0t got %h want %h", $time, a, e); end end
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] charge_pct = 8'h00;
    logic charge_valid = 1'b0;
    logic restart_estimate_pin = 1'b0;
    gcar_pkg::gcar_wr_req_t wr_req;
    logic [7:0] rd_addr, battery_comp_value, lvl;
    logic [15:0] rd_data, q;
    logic no_ack, gauge_run, sleep_mode, quick_start, full_reset, alert_pin_n;
    int err_count = 0;
    int total_checks = 0;
    int n;
    // written word beside the word read back
    logic [31:0] rows [4] = '{32'h12FF_129F, 32'hA5C3_A583,
        32'h0000_0000, 32'hFF1F_FF1F};
    logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h1C, 5'h1F};
    always #20 clk = ~clk;
    gcar_regs gcar_regs_i (.clk(clk), .rst(rst), .wr_req(wr_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .no_ack(no_ack),
        .charge_pct(charge_pct), .charge_valid(charge_valid),
        .restart_estimate_pin(restart_estimate_pin),
        .battery_comp_value(battery_comp_value), .gauge_run(gauge_run),
        .sleep_mode(sleep_mode), .quick_start(quick_start),
        .full_reset(full_reset), .alert_pin_n(alert_pin_n));
    gcar_host gcar_host_i (.clk(clk), .rd_data(rd_data), .wr_req(wr_req),
        .rd_addr(rd_addr));
    // one new charge estimate
    task automatic chg(input logic [7:0] p);
        @(negedge clk);
        charge_pct = p;
        charge_valid = 1'b1;
        @(negedge clk);
        charge_valid = 1'b0;
    endtask
    task automatic summarize();
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        gcar_host_i.rd(8'h0C, q);
        `CHK(q, 16'h971C)
        `CHK(gauge_run, 1'b1)
        for (n = 0; n < 4; n++) begin
            gcar_host_i.wr(8'h0C, rows[n][31:16], 1'b1);
            gcar_host_i.rd(8'h0C, q);
            `CHK(q, rows[n][15:0])
            `CHK(battery_comp_value, rows[n][31:24])
            `CHK(gauge_run, ~rows[n][23])
        end
        // four threshold codes (0, 1, 1C, 1F): at level arms, one below fires
        for (n = 0; n < 4; n++) begin
            lvl = 8'h20 - {3'b000, codes[n]};
            gcar_host_i.wr(8'h0C, {8'h97, 3'b000, codes[n]}, 1'b1);
            chg(lvl);
            `CHK(alert_pin_n, 1'b1)
            chg(lvl - 8'h01);
            `CHK(alert_pin_n, 1'b0)
            gcar_host_i.rd(8'h0C, q);
            `CHK(q[5], 1'b1)
            gcar_host_i.wr(8'h0C, {8'h97, 3'b000, codes[n]}, 1'b1);
            `CHK(alert_pin_n, 1'b1)
            chg(lvl - 8'h01);
            `CHK(alert_pin_n, 1'b1)
        end
        // alert survives sleep; pin checked after fresh estimates while still asleep
        chg(8'h01);
        chg(8'h00);
        gcar_host_i.wr(8'h0C, 16'h97BF, 1'b1);
        `CHK(alert_pin_n, 1'b0)
        gcar_host_i.wr(8'h0C, 16'h979F, 1'b1);
        chg(8'h01);
        chg(8'h00);
        `CHK(alert_pin_n, 1'b1)
        gcar_host_i.wr(8'h0C, 16'h1234, 1'b0);
        gcar_host_i.wr(8'hFE, 16'h0054, 1'b0);
        gcar_host_i.rd(8'h0C, q);
        `CHK(q, 16'h979F)
        gcar_host_i.wr(8'hFE, 16'h0055, 1'b1);
        `CHK(full_reset, 1'b0)
        gcar_host_i.wr(8'hFE, 16'h0054, 1'b1);
        `CHK({full_reset, no_ack}, 2'b11)
        gcar_host_i.rd(8'h0C, q);
        `CHK(q, 16'h971C)
        gcar_host_i.rd(8'h04, q);
        `CHK(q, 16'h0000)
        @(negedge clk);
        restart_estimate_pin = 1'b1;
        for (n = 0; n < 8 && quick_start !== 1'b1; n++)
            @(negedge clk);
        if (n == 8) begin
            err_count++;
        end
        `CHK(quick_start, 1'b1)
        summarize();
    end
endmodule // tb
bind gcar_regs gcar_monitor #(.CHARGE_W(CHARGE_W)) gcar_monitor_i (
    .clk(clk), .rst(rst), .wr_req(wr_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .no_ack(no_ack), .charge_pct(charge_pct),
    .charge_valid(charge_valid), .restart_estimate_pin(restart_estimate_pin),
    .battery_comp_value(battery_comp_value), .gauge_run(gauge_run),
    .sleep_mode(sleep_mode), .quick_start(quick_start),
    .full_reset(full_reset), .alert_pin_n(alert_pin_n));
